/* design/sfspi_defines.svh */
`ifndef SFSPI_DEFINES_SVH
`define SFSPI_DEFINES_SVH
// Functional notes
// - device works in clock modes 0 and 3; host uses one of them
// - select falling starts an operation; select rising ends it
// - serial output line floats whenever select is high
// - deselection puts the device in standby, not deep power-down
// - input line is ignored entirely while select is high
// - standby waits until a self-timed program or erase finishes
// - command, address and data bits sampled on rising shift clock
// - output data changes only on falling shift clock edges
// - dual read turns input line into lane zero output, two bits per fall
// - dual read keeps output line driving lane one, higher bit of pair
// - write guard low locks protected sectors; pulled high means unlocked
// - erase spans: 256-byte page, 4, 32, 64 kilobyte blocks, whole array
// - program writes 1 to 256 bytes over single or dual input lanes
// - 128-byte one-time area: 64 factory bytes, 64 user bytes
// - pause low ignores clock and input, floats output, keeps selection

`define SFSPI_SYNC_RST 6'h3f
`define SFSPI_FIFO_DEPTH 16
`define SFSPI_FIFO_WIDTH 9
`define SFSPI_PROG_MAX 9'h100
`define SFSPI_SPAN_PAGE 19'h00100
`define SFSPI_SPAN_4K 19'h01000
`define SFSPI_SPAN_32K 19'h08000
`define SFSPI_SPAN_64K 19'h10000
`define SFSPI_SPAN_CHIP 19'h40000
`define SFSPI_OTP_USER_BASE 7'h40
`define SFSPI_IDX_CS 5
`define SFSPI_IDX_SCK 4
`define SFSPI_IDX_SI 3
`define SFSPI_IDX_SO 2
`define SFSPI_IDX_PAUSE 1
`define SFSPI_IDX_WG 0
`endif

/* design/sfspi_front_end.sv */
`timescale 1ns/1ns
`include "sfspi_defines.svh"

module sfspi_fifo #(
    parameter int WIDTH = `SFSPI_FIFO_WIDTH,
    parameter int DEPTH = `SFSPI_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            count <= next_count;
            in_ready <= next_count != (AW+1)'(DEPTH);
            out_valid <= next_count != '0;
        end
    end
endmodule

module sfspi_front_end (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic device_select_n,
    input wire logic shift_clock,
    input wire logic serial_in_line,
    output logic dual_lane_zero_out,
    output logic dual_lane_zero_oe,
    input wire logic dual_lane_one_in,
    output logic serial_out_line_out,
    output logic serial_out_line_oe,
    input wire logic pause_n,
    input wire logic write_guard_n,
    output logic rx_valid,
    output sfspi_pkg::sfspi_rx_word_t rx_word,
    input wire logic rx_ready,
    output logic rx_overrun,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    output logic tx_taken,
    input wire sfspi_pkg::sfspi_out_mode_t out_mode,
    input wire logic dual_in,
    input wire logic core_busy,
    output logic frame_active,
    output logic standby,
    output logic write_lock,
    output logic [8:0] frame_bytes,
    input wire sfspi_pkg::sfspi_erase_kind_t erase_kind,
    output logic [18:0] erase_span,
    input wire logic [6:0] otp_addr,
    output logic otp_write_ok
);
    import sfspi_pkg::*;

    function automatic logic [18:0] span_of(input sfspi_erase_kind_t kind);
        unique case (kind)
            SFSPI_ERASE_PAGE: span_of = `SFSPI_SPAN_PAGE;
            SFSPI_ERASE_4K: span_of = `SFSPI_SPAN_4K;
            SFSPI_ERASE_32K: span_of = `SFSPI_SPAN_32K;
            SFSPI_ERASE_64K: span_of = `SFSPI_SPAN_64K;
            SFSPI_ERASE_CHIP: span_of = `SFSPI_SPAN_CHIP;
            default: span_of = '0;
        endcase
    endfunction

    // two-stage synchronisers for every pin
    logic [5:0] pin_raw;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic sck_d;

    assign pin_raw = {device_select_n, shift_clock, serial_in_line,
                      dual_lane_one_in, pause_n, write_guard_n};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    sync1[gi] <= 1'(`SFSPI_SYNC_RST >> gi);
                    sync2[gi] <= 1'(`SFSPI_SYNC_RST >> gi);
                end else begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    wire cs_n_s = sync2[`SFSPI_IDX_CS];
    wire sck_s = sync2[`SFSPI_IDX_SCK];
    wire si_s = sync2[`SFSPI_IDX_SI];
    wire so_s = sync2[`SFSPI_IDX_SO];
    wire pause_s = sync2[`SFSPI_IDX_PAUSE];
    wire guard_s = sync2[`SFSPI_IDX_WG];

    // edges work in both idle-low and idle-high clock modes
    wire sck_rise = sck_s & ~sck_d;
    wire sck_fall = ~sck_s & sck_d;

    sfspi_link_state_t state;
    sfspi_link_state_t next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            SFSPI_IDLE: begin
                if (!cs_n_s) begin
                    next_state = SFSPI_SELECT;
                end
            end
            SFSPI_SELECT: begin
                if (cs_n_s) begin
                    next_state = SFSPI_IDLE;
                end else if (!pause_s && !sck_s) begin
                    next_state = SFSPI_PAUSE;
                end
            end
            SFSPI_PAUSE: begin
                if (cs_n_s) begin
                    next_state = SFSPI_IDLE;
                end else if (pause_s) begin
                    next_state = SFSPI_SELECT;
                end
            end
            default: next_state = SFSPI_IDLE;
        endcase
    end

    // shifting only while selected and not paused
    wire live = (state == SFSPI_SELECT) && !cs_n_s && pause_s;
    wire frame_start = (state == SFSPI_IDLE) && !cs_n_s;
    wire out_on = live && (out_mode != SFSPI_OUT_NONE);
    wire out_dual = out_mode == SFSPI_OUT_DUAL;

    // receive path
    logic [7:0] rx_sr;
    logic [2:0] rx_cnt;
    logic first_pending;
    logic push_valid;
    sfspi_rx_word_t push_word;
    logic fifo_in_ready;

    wire rx_take = live && sck_rise && !out_dual;
    wire [7:0] next_rx_sr = dual_in ? {rx_sr[5:0], so_s, si_s}
                                    : {rx_sr[6:0], si_s};
    wire [2:0] rx_step = dual_in ? 3'h2 : 3'h1;
    wire rx_done = rx_take && (rx_cnt == (dual_in ? 3'h6 : 3'h7));

    // transmit path
    logic [7:0] tx_sr;
    logic [2:0] tx_cnt;
    wire tx_load = tx_cnt == 3'h0;
    wire [7:0] tx_cur = tx_load ? (tx_valid ? tx_byte : 8'hff) : tx_sr;
    wire tx_shift = out_on && sck_fall;
    wire [2:0] tx_step = out_dual ? 3'h2 : 3'h1;
    wire [7:0] next_tx_sr = out_dual ? {tx_cur[5:0], 2'h0} : {tx_cur[6:0], 1'h0};
    logic tx_driven;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= SFSPI_IDLE;
            // matches the synchroniser reset level, so no false edge follows reset
            sck_d <= 1'b1;
        end else begin
            state <= next_state;
            sck_d <= sck_s;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || frame_start) begin
            rx_sr <= 8'h00;
            rx_cnt <= 3'h0;
        end else if (rx_take) begin
            rx_sr <= next_rx_sr;
            rx_cnt <= rx_cnt + rx_step;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            push_valid <= 1'b0;
            push_word <= '0;
            first_pending <= 1'b0;
            frame_bytes <= 9'h000;
        end else begin
            push_valid <= rx_done;
            if (rx_done) begin
                push_word <= '{first: first_pending, data: next_rx_sr};
            end
            if (frame_start) begin
                first_pending <= 1'b1;
                frame_bytes <= 9'h000;
            end else if (rx_done) begin
                first_pending <= 1'b0;
                if (frame_bytes != `SFSPI_PROG_MAX) begin
                    frame_bytes <= frame_bytes + 9'h001;
                end
            end
        end
    end

    // a full buffer drops the byte and flags it until the next frame
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_overrun <= 1'b0;
        end else if (push_valid && !fifo_in_ready) begin
            rx_overrun <= 1'b1;
        end else if (frame_start) begin
            rx_overrun <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || frame_start) begin
            tx_sr <= 8'hff;
            tx_cnt <= 3'h0;
        end else if (tx_shift) begin
            tx_sr <= next_tx_sr;
            tx_cnt <= tx_cnt + tx_step;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            serial_out_line_out <= 1'b0;
            dual_lane_zero_out <= 1'b0;
            tx_taken <= 1'b0;
            tx_driven <= 1'b0;
        end else begin
            tx_taken <= tx_shift && tx_load && tx_valid;
            if (tx_shift) begin
                serial_out_line_out <= tx_cur[7];
                dual_lane_zero_out <= tx_cur[6];
            end
            if (state == SFSPI_IDLE) begin
                tx_driven <= 1'b0;
            end else if (tx_shift) begin
                tx_driven <= 1'b1;
            end
        end
    end

    // enables drop at once on deselect or pause
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            serial_out_line_oe <= 1'b0;
            dual_lane_zero_oe <= 1'b0;
        end else begin
            serial_out_line_oe <= out_on && (tx_driven || tx_shift);
            dual_lane_zero_oe <= out_on && out_dual && (tx_driven || tx_shift);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            frame_active <= 1'b0;
            standby <= 1'b0;
            write_lock <= 1'b0;
            erase_span <= '0;
            otp_write_ok <= 1'b0;
        end else begin
            frame_active <= state != SFSPI_IDLE;
            standby <= (state == SFSPI_IDLE) && !core_busy;
            write_lock <= !guard_s;
            erase_span <= span_of(erase_kind);
            otp_write_ok <= otp_addr >= `SFSPI_OTP_USER_BASE;
        end
    end

    logic [8:0] fifo_out;

    sfspi_fifo #(
        .WIDTH(`SFSPI_FIFO_WIDTH),
        .DEPTH(`SFSPI_FIFO_DEPTH)
    ) u_rx_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(push_valid),
        .in_data(push_word),
        .in_ready(fifo_in_ready),
        .out_valid(rx_valid),
        .out_data(fifo_out),
        .out_ready(rx_ready)
    );

    assign rx_word = sfspi_rx_word_t'(fifo_out);
endmodule

/* design/sfspi_pkg.sv */
package sfspi_pkg;
    typedef struct packed {
        logic first;
        logic [7:0] data;
    } sfspi_rx_word_t;
    typedef enum logic [1:0] {SFSPI_OUT_NONE, SFSPI_OUT_SINGLE, SFSPI_OUT_DUAL} sfspi_out_mode_t;
    typedef enum logic [2:0] {
        SFSPI_ERASE_PAGE, SFSPI_ERASE_4K, SFSPI_ERASE_32K, SFSPI_ERASE_64K, SFSPI_ERASE_CHIP
    } sfspi_erase_kind_t;
    typedef enum logic [1:0] {SFSPI_IDLE, SFSPI_SELECT, SFSPI_PAUSE} sfspi_link_state_t;
endpackage

/* testbench/sfspi_front_end_props.sv */
`timescale 1ns/1ns
module sfspi_front_end_props
    import sfspi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic device_select_n,
    input wire logic shift_clock,
    input wire logic pause_n,
    input wire logic write_guard_n,
    input wire logic core_busy,
    input wire logic tx_valid,
    input wire logic tx_taken,
    input wire logic serial_out_line_out,
    input wire logic serial_out_line_oe,
    input wire logic dual_lane_zero_oe,
    input wire logic standby,
    input wire logic write_lock,
    input wire logic [8:0] frame_bytes,
    input wire sfspi_pkg::sfspi_erase_kind_t erase_kind,
    input wire logic [18:0] erase_span,
    input wire logic [6:0] otp_addr,
    input wire logic otp_write_ok
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire [18:0] exp_span = erase_kind == SFSPI_ERASE_PAGE ? 19'h00100 :
        erase_kind == SFSPI_ERASE_4K ? 19'h01000 : erase_kind == SFSPI_ERASE_32K ? 19'h08000 :
        erase_kind == SFSPI_ERASE_64K ? 19'h10000 : 19'h40000;
    AST_SO_FLOAT: assert property (device_select_n [*6] |-> !serial_out_line_oe && !dual_lane_zero_oe)
        else $error("output lane driven while deselected");
    AST_STANDBY_ON: assert property ((device_select_n && !core_busy) [*8] |-> standby)
        else $error("no standby after deselect");
    AST_STANDBY_WAIT: assert property (core_busy |=> !standby)
        else $error("standby during busy core");
    AST_DESEL_IGNORE: assert property (device_select_n [*6] |=> $stable(frame_bytes))
        else $error("byte taken while deselected");
    AST_PAUSE_FLOAT: assert property ((!pause_n && !shift_clock && !device_select_n) [*6]
        |-> !serial_out_line_oe && !dual_lane_zero_oe) else $error("output driven in pause");
    AST_OUT_ON_FALL: assert property (serial_out_line_oe && $past(serial_out_line_oe)
        && $changed(serial_out_line_out) |-> !shift_clock) else $error("output moved off fall");
    AST_TX_TAKEN: assert property (tx_taken |-> !shift_clock && $past(tx_valid))
        else $error("byte taken without valid or off fall");
    AST_WLOCK_OFF: assert property (write_guard_n [*4] |-> !write_lock)
        else $error("lock while guard high");
    AST_WLOCK_ON: assert property (!write_guard_n [*4] |-> write_lock)
        else $error("no lock while guard low");
    AST_SPAN: assert property (!$past(rst) |-> erase_span == $past(exp_span))
        else $error("erase span wrong");
    AST_OTP: assert property (!$past(rst) |-> otp_write_ok == ($past(otp_addr) >= 7'h40))
        else $error("one time area guard wrong");
    AST_BYTES_MAX: assert property (frame_bytes <= 9'h100)
        else $error("frame byte count past ceiling");
endmodule
bind sfspi_front_end sfspi_front_end_props sfspi_front_end_props_i (.*);

/* testbench/sfspi_host_model.sv */
`timescale 1ns/1ns
module sfspi_host_model (
    output logic device_select_n,
    output logic shift_clock,
    output logic si_drv,
    output logic lane1_drv,
    output logic pause_n,
    input wire logic serial_in_line,
    input wire logic dual_lane_one_in
);
    logic cpol = 1'b0;
    initial begin
        device_select_n = 1'b1;
        shift_clock = 1'b0;
        si_drv = 1'b1;
        lane1_drv = 1'b1;
        pause_n = 1'b1;
    end
    // one link clock period, both lanes sampled at the rise
    task automatic edge2(input logic [1:0] b, input logic d, output logic [1:0] r);
        if (cpol) shift_clock = 1'b0;
        si_drv = d ? b[0] : b[1];
        lane1_drv = d ? b[1] : ~lane1_drv;
        #62 shift_clock = 1'b1;
        r = {dual_lane_one_in, serial_in_line};
        #63 if (!cpol) shift_clock = 1'b0;
    endtask
    // mode 0 single, 1 dual in, 2 dual out with both host lanes driven toggled each period; msb first
    task automatic frame(input logic [7:0] tx [$], input int mode, input int pz,
        output logic [7:0] rx [$]);
        logic [7:0] sh;
        logic [1:0] r;
        rx = {};
        #1 shift_clock = cpol;
        device_select_n = 1'b0;
        #31;
        foreach (tx[k]) begin
            sh = tx[k];
            if (k == pz) begin
                pause_n = 1'b0; // only with the clock low
                #31 repeat (2) edge2(2'b00, 1'b0, r);
                pause_n = 1'b1;
                #31;
            end
            repeat (mode != 0 ? 4 : 8) begin
                edge2(mode == 2 ? ~{lane1_drv, si_drv} : sh[7:6], mode != 0, r);
                sh = mode != 0 ? {sh[5:0], r} : {sh[6:0], r[1]};
            end
            rx.push_back(sh);
        end
        #31 device_select_n = 1'b1;
    endtask
endmodule

/* testbench/tb_serial_flash_spi_front_end.sv */
`timescale 1ns/1ns
module tb_serial_flash_spi_front_end;
    import sfspi_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic serial_in_line, dual_lane_one_in, si_drv, lane1_drv, device_select_n, shift_clock;
    logic pause_n, dual_lane_zero_out, dual_lane_zero_oe, serial_out_line_out, serial_out_line_oe;
    logic write_guard_n = 1'b1, rx_ready = 1'b0, tx_valid = 1'b0, dual_in = 1'b0, core_busy = 1'b0;
    logic rx_valid, rx_overrun, tx_taken, frame_active, standby, write_lock, otp_write_ok;
    logic [7:0] tx_byte = 8'h00;
    logic [8:0] frame_bytes;
    logic [18:0] erase_span;
    logic [6:0] otp_addr = 7'h00;
    sfspi_rx_word_t rx_word;
    sfspi_out_mode_t out_mode = SFSPI_OUT_NONE;
    sfspi_erase_kind_t erase_kind = SFSPI_ERASE_PAGE;
    int bad_count = 0, num_checks = 0, cyc = 0;
    logic [7:0] q [$];
    logic [7:0] got [$];
    logic [1:0] r;
    logic [18:0] spans [5] = '{19'h00100, 19'h01000, 19'h08000, 19'h10000, 19'h40000};
    always #5 ref_clk = ~ref_clk;
    assign serial_in_line = dual_lane_zero_oe ? dual_lane_zero_out : si_drv;
    assign dual_lane_one_in = serial_out_line_oe ? serial_out_line_out : lane1_drv;
    sfspi_front_end sfspi_front_end_i (.*);
    sfspi_host_model sfspi_host_model_i (.*);
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic drain(input logic [8:0] e [$]);
        foreach (e[k]) begin
            repeat (4) if (rx_valid !== 1'b1) @(negedge ref_clk);
            chk(rx_word, e[k]);
            rx_ready = 1'b1;
            @(negedge ref_clk) rx_ready = 1'b0;
        end
        chk(rx_valid, 1'b0);
    endtask
    task automatic t_static();
        write_guard_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk(write_lock, 1'b1);
        write_guard_n = 1'b1;
        for (int k = 0; k < 5; k++) begin
            erase_kind = sfspi_erase_kind_t'(k);
            otp_addr = 7'h3f + 7'(k & 1);
            @(negedge ref_clk);
            chk(erase_span, spans[k]);
            chk(otp_write_ok, k & 1);
        end
        chk(write_lock, 1'b0);
    endtask
    task automatic t_idle();
        #1 repeat (8) sfspi_host_model_i.edge2(2'b01, 1'b0, r);
        @(negedge ref_clk);
        chk(rx_valid, 1'b0);
        chk({serial_out_line_oe, frame_active, standby}, 3'b001);
        core_busy = 1'b1;
        q = {8'h00};
        sfspi_host_model_i.frame(q, 0, -1, got);
        repeat (8) @(negedge ref_clk);
        chk(standby, 1'b0);
        core_busy = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(standby, 1'b1);
        drain({9'h100});
    endtask
    task automatic t_fifo();
        logic [8:0] e [$];
        q = {};
        for (int i = 0; i < 17; i++) q.push_back(8'h81 + 8'(i));
        sfspi_host_model_i.frame(q, 0, -1, got);
        @(negedge ref_clk);
        chk({rx_overrun, frame_bytes}, {1'b1, 9'd17});
        for (int i = 0; i < 16; i++) e.push_back({i == 0, q[i]});
        drain(e);
    endtask
    task automatic t_pause();
        q = {8'h5a, 8'hff};
        sfspi_host_model_i.frame(q, 0, 1, got);
        @(negedge ref_clk);
        chk(rx_overrun, 1'b0);
        drain({9'h15a, 9'h0ff});
        dual_in = 1'b1;
        q = {8'h4b};
        sfspi_host_model_i.frame(q, 1, -1, got);
        @(negedge ref_clk) dual_in = 1'b0;
        drain({9'h14b});
    endtask
    task automatic t_read(input sfspi_out_mode_t m, input logic [7:0] b);
        sfspi_host_model_i.cpol = 1'b1;
        out_mode = m;
        tx_byte = b;
        tx_valid = 1'b1;
        q = {8'h00};
        sfspi_host_model_i.frame(q, m == SFSPI_OUT_DUAL ? 2 : 0, -1, got);
        @(negedge ref_clk);
        chk(got[0], b);
        chk(frame_bytes, m == SFSPI_OUT_DUAL ? 9'd0 : 9'd1);
        tx_valid = 1'b0;
        out_mode = SFSPI_OUT_NONE;
    endtask
    initial begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        t_static();
        t_idle();
        t_fifo();
        t_pause();
        t_read(SFSPI_OUT_SINGLE, 8'h96);
        drain({9'h100});
        t_read(SFSPI_OUT_DUAL, 8'hc6);
        results();
    end
endmodule
